// *** pkg/fohr_defs.svh ***
// Constants for the fan override, hysteresis and ramp supervisor
`ifndef FOHR_DEFS_SVH
`define FOHR_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define FOHR_MCLK_HZ         20000000
`define FOHR_MS_PER_S        1000
`define FOHR_DUTY_STEPS      255
`define FOHR_SLOW_FACTOR     4
`define FOHR_RAMP_CNT_W      25

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FOHR_ADDR_RAMP_SLOW  8'h10
`define FOHR_ADDR_PROC_LIM   8'h3D
`define FOHR_ADDR_REMOTE_ONE_RAMP_SELECT_ONE   8'h62
`define FOHR_ADDR_REMOTE_ONE_RAMP_SELECT_TWO   8'h63
`define FOHR_ADDR_R1_LIM     8'h6A
`define FOHR_ADDR_LOC_LIM    8'h6B
`define FOHR_ADDR_R2_LIM     8'h6C
`define FOHR_ADDR_HYST_A     8'h6D
`define FOHR_ADDR_HYST_B     8'h6E

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define FOHR_RST_RAMP_SLOW   8'h00
`define FOHR_RST_PROC_LIM    8'h00
`define FOHR_RST_REMOTE_ONE_RAMP_SELECT        8'h00
`define FOHR_RST_CRIT_LIM    8'h64
`define FOHR_RST_HYST        8'h44
`define FOHR_MASK_RAMP_SLOW  8'h87
`define FOHR_MASK_REMOTE_ONE_RAMP_SELECT_ONE   8'hE7
`define FOHR_MASK_REMOTE_ONE_RAMP_SELECT_TWO   8'h77
`define FOHR_DUTY_FULL       8'hFF
`define FOHR_DUTY_OFF        8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FOHR_BIT_EXTRA_SLOW  7
`define FOHR_BIT_STAY_OUT1   5
`define FOHR_RAMP_LO_LSB     0
`define FOHR_RAMP_HI_LSB     4

// ----------------------------------------------------------------
// Full-scale ramp times in ms, normal and extended
// ----------------------------------------------------------------
`define FOHR_RAMP_MS_0       37500
`define FOHR_RAMP_MS_1       18800
`define FOHR_RAMP_MS_2       12500
`define FOHR_RAMP_MS_3       7500
`define FOHR_RAMP_MS_4       4700
`define FOHR_RAMP_MS_5       3100
`define FOHR_RAMP_MS_6       1600
`define FOHR_RAMP_MS_7       800
`define FOHR_XRAMP_MS_0      52200
`define FOHR_XRAMP_MS_1      26100
`define FOHR_XRAMP_MS_2      17400
`define FOHR_XRAMP_MS_3      10400
`define FOHR_XRAMP_MS_4      6500
`define FOHR_XRAMP_MS_5      4400
`define FOHR_XRAMP_MS_6      2200
`define FOHR_XRAMP_MS_7      1100

// Temperature span table scaled by six, so all entries are whole numbers
`define FOHR_SPAN_SCALE      6
`define FOHR_SPAN6_TABLE     {12'd480, 12'd320, 12'd240, 12'd192, 12'd160, 12'd120, 12'd96, 12'd80, \
                              12'd60, 12'd48, 12'd40, 12'd30, 12'd24, 12'd20, 12'd15, 12'd12}

`endif

// *** pkg/fohr_pkg.sv ***
// Types shared by the fan supervisor and its ramp limiter
package fohr_pkg;
  `include "fohr_defs.svh"

  typedef logic [7:0] fohr_byte_t;

  // Automatic curve settings for one output
  typedef struct packed {
    fohr_byte_t start_temp;
    logic [3:0] span_code;
    fohr_byte_t min_duty;
    fohr_byte_t max_duty;
  } fohr_curve_s;

  typedef struct packed {
    fohr_byte_t ramp_slow_config;
    fohr_byte_t proc_control_temp_limit;
    fohr_byte_t acoustics_ctrl_one;
    fohr_byte_t acoustics_ctrl_two;
    fohr_byte_t remote_one_crit_limit;
    fohr_byte_t local_crit_limit;
    fohr_byte_t remote_two_crit_limit;
    fohr_byte_t hyst_remote_one_local;
    fohr_byte_t hyst_remote_two_proc;
  } fohr_regs_s;

  typedef struct packed {
    fohr_regs_s            regs;
    logic [3:0]            crit;
    logic                  ovr;
    logic [2:0]            fan_on;
    logic [2:0][7:0]       duty;
    fohr_byte_t            rdata;
  } fohr_state_s;

  typedef struct packed {
    logic [`FOHR_RAMP_CNT_W-1:0] cnt;
    fohr_byte_t                  duty;
  } fohr_ramp_s;
endpackage

// *** rtl/fohr_ramp.sv ***
// Duty-cycle slew limiter for one output
`timescale 1ns/100ps
module fohr_ramp
  import fohr_pkg::*;
(
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  // Control
  input  wire logic [7:0]                  target,
  input  wire logic [`FOHR_RAMP_CNT_W-1:0] interval,
  input  wire logic                        force_full,
  // Result
  output logic      [7:0]                  duty
);

  fohr_ramp_s st_r;
  fohr_ramp_s st_nxt;

  // ----------------------------------------------------------------
  // One count per interval toward the target
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (force_full) begin
      st_nxt.duty = `FOHR_DUTY_FULL;
      st_nxt.cnt  = '0;
    end else if (st_r.duty == target) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= interval - `FOHR_RAMP_CNT_W'd1) begin
      st_nxt.cnt = '0;
      if (st_r.duty < target) begin
        st_nxt.duty = st_r.duty + 8'h01;
      end else begin
        st_nxt.duty = st_r.duty - 8'h01;
      end
    end else begin
      st_nxt.cnt = st_r.cnt + `FOHR_RAMP_CNT_W'd1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.cnt  <= '0;
      st_r.duty <= `FOHR_DUTY_FULL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign duty = st_r.duty;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ramp_unit_step: assert property (@(posedge mclk) disable iff (!arst_n)
    !force_full |=> (st_r.duty == $past(st_r.duty) || st_r.duty == $past(st_r.duty) + 8'h01 ||
                     st_r.duty == $past(st_r.duty) - 8'h01 || st_r.duty == `FOHR_DUTY_FULL))
    else $error("duty moved by more than one count");

  a_ramp_idle_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_r.duty == target && !force_full) |=> (st_r.cnt == '0 && st_r.duty == $past(st_r.duty)))
    else $error("ramp moved while on target");

  a_ramp_interval: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_r.duty != target && !force_full && st_r.cnt < interval - `FOHR_RAMP_CNT_W'd1)
      |=> (st_r.duty == $past(st_r.duty) && st_r.cnt == $past(st_r.cnt) + `FOHR_RAMP_CNT_W'd1))
    else $error("ramp stepped before its interval");

  a_ramp_step_due: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_r.duty != target && !force_full && st_r.cnt >= interval - `FOHR_RAMP_CNT_W'd1)
      |=> (st_r.duty != $past(st_r.duty) && st_r.cnt == '0))
    else $error("ramp missed a due step");

endmodule

// *** rtl/fohr_supervisor.sv ***
// Fan critical override, on/off hysteresis and duty ramp supervisor
//
// Function
// - Any channel above its critical limit drives every output at full duty.
// - Override holds until that channel falls below limit minus its hysteresis.
// - Override ignores automatic curve settings; it cannot be masked.
// - Processor channel uses its control-temperature limit as critical limit.
// - Diode critical limits reset to 0x64; processor limit resets to 0x00.
// - Four-bit hysteresis nibbles per channel in two registers, each resetting to 4.
// - One hysteresis field serves both override release and fan off threshold.
// - Stay-on bits 5..7 pick zero or minimum duty below start minus hysteresis.
// - With stay-on set, hysteresis has no effect when falling below start.
// - Duty moves gradually toward the curve value instead of jumping.
// - Remote one ramp code selects 37.5 down to 0.8 second full-scale times.
// - Second smoothing register holds local ramp in 2:0 and remote two in 6:4.
// - Extended ramp bit switches the table to 52.2 down to 1.1 seconds.
// - Per-channel slow bit lengthens that channel's ramp by four.
// - Above start, duty rises linearly from minimum toward full across the span, clamped at maximum duty.
// - Maximum duty never restrains the critical override.
`timescale 1ns/100ps
module fohr_supervisor
  import fohr_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `FOHR_MCLK_HZ / `FOHR_MS_PER_S
)
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // Register port from the management bus engine
  input  wire logic                 reg_wr_en,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // Temperatures: 0 remote one, 1 local, 2 remote two, 3 processor
  input  wire logic [3:0][7:0]      chan_temp,
  // Automatic curve settings per output
  input  wire fohr_curve_s [2:0]    curve_cfg,
  // Fan drive and status
  output logic      [2:0][7:0]      pwm_duty,
  output logic      [3:0]           crit_active,
  output logic                      override_active
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [3:0] b);
    logic [8:0] d;
    d = {1'b0, a} - {5'h00, b};
    return d[8] ? 8'h00 : d[7:0];
  endfunction

  function automatic int unsigned ramp_ms(input logic [2:0] code, input logic ext);
    int unsigned ms;
    ms = 0;
    unique case (code)
      3'h0: ms = ext ? `FOHR_XRAMP_MS_0 : `FOHR_RAMP_MS_0;
      3'h1: ms = ext ? `FOHR_XRAMP_MS_1 : `FOHR_RAMP_MS_1;
      3'h2: ms = ext ? `FOHR_XRAMP_MS_2 : `FOHR_RAMP_MS_2;
      3'h3: ms = ext ? `FOHR_XRAMP_MS_3 : `FOHR_RAMP_MS_3;
      3'h4: ms = ext ? `FOHR_XRAMP_MS_4 : `FOHR_RAMP_MS_4;
      3'h5: ms = ext ? `FOHR_XRAMP_MS_5 : `FOHR_RAMP_MS_5;
      3'h6: ms = ext ? `FOHR_XRAMP_MS_6 : `FOHR_RAMP_MS_6;
      3'h7: ms = ext ? `FOHR_XRAMP_MS_7 : `FOHR_RAMP_MS_7;
    endcase
    return ms;
  endfunction

  // Cycles per one-count step; longest time, so rounds down, never below one
  function automatic logic [`FOHR_RAMP_CNT_W-1:0] step_cycles(input logic [2:0] code,
                                                              input logic       ext,
                                                              input logic       slow);
    longint unsigned t;
    t = longint'(ramp_ms(code, ext)) * longint'(CYC_PER_MS);
    if (slow) begin
      t = t * longint'(`FOHR_SLOW_FACTOR);
    end
    t = t / longint'(`FOHR_DUTY_STEPS);
    if (t == 0) begin
      t = 1;
    end
    return t[`FOHR_RAMP_CNT_W-1:0];
  endfunction

  function automatic logic [11:0] span6(input logic [3:0] code);
    logic [15:0][11:0] tbl;
    tbl = `FOHR_SPAN6_TABLE;
    return tbl[code];
  endfunction

  // Linear curve from minimum at start to full at start plus span, clamped
  function automatic logic [7:0] afc_duty(input logic [7:0] temp, input fohr_curve_s cv);
    logic [7:0]  dt;
    logic [7:0]  room;
    logic [19:0] num;
    logic [19:0] lvl;
    logic [7:0]  duty;
    dt   = temp - cv.start_temp;
    room = `FOHR_DUTY_FULL - cv.min_duty;
    num  = 20'({12'h000, dt} * 20'(`FOHR_SPAN_SCALE)) * {12'h000, room};
    lvl  = {12'h000, cv.min_duty} + num / {8'h00, span6(cv.span_code)};
    duty = (lvl > 20'h000FF) ? `FOHR_DUTY_FULL : lvl[7:0];
    return (duty > cv.max_duty) ? cv.max_duty : duty;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fohr_state_s                         st_r;
  fohr_state_s                         st_nxt;
  logic [3:0][3:0]                     chan_hyst;
  logic [3:0][7:0]                     chan_lim;
  logic [2:0][2:0]                     ramp_code;
  logic [2:0]                          stay_on;
  logic [2:0][7:0]                     duty_tgt;
  logic [2:0][7:0]                     ramp_duty;
  logic [2:0][`FOHR_RAMP_CNT_W-1:0]    ramp_int;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  assign chan_hyst[0] = st_r.regs.hyst_remote_one_local[7:4];
  assign chan_hyst[1] = st_r.regs.hyst_remote_one_local[3:0];
  assign chan_hyst[2] = st_r.regs.hyst_remote_two_proc[7:4];
  assign chan_hyst[3] = st_r.regs.hyst_remote_two_proc[3:0];
  assign chan_lim[0]  = st_r.regs.remote_one_crit_limit;
  assign chan_lim[1]  = st_r.regs.local_crit_limit;
  assign chan_lim[2]  = st_r.regs.remote_two_crit_limit;
  assign chan_lim[3]  = st_r.regs.proc_control_temp_limit;
  assign ramp_code[0] = st_r.regs.acoustics_ctrl_one[`FOHR_RAMP_LO_LSB +: 3];
  assign ramp_code[1] = st_r.regs.acoustics_ctrl_two[`FOHR_RAMP_LO_LSB +: 3];
  assign ramp_code[2] = st_r.regs.acoustics_ctrl_two[`FOHR_RAMP_HI_LSB +: 3];
  assign stay_on      = st_r.regs.acoustics_ctrl_one[`FOHR_BIT_STAY_OUT1 +: 3];

  // ----------------------------------------------------------------
  // Per-output target and ramp
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_out
    logic ext_bit;
    assign ext_bit = st_r.regs.ramp_slow_config[`FOHR_BIT_EXTRA_SLOW];
    assign ramp_int[i] = step_cycles(ramp_code[i], ext_bit,
                                     st_r.regs.ramp_slow_config[i]);

    always_comb begin
      if (!st_r.fan_on[i]) begin
        duty_tgt[i] = stay_on[i] ? curve_cfg[i].min_duty : `FOHR_DUTY_OFF;
      end else if (chan_temp[i] <= curve_cfg[i].start_temp) begin
        duty_tgt[i] = curve_cfg[i].min_duty;
      end else begin
        duty_tgt[i] = afc_duty(chan_temp[i], curve_cfg[i]);
      end
    end

    fohr_ramp u_ramp (
      .mclk       (mclk),
      .arst_n     (arst_n),
      .target     (duty_tgt[i]),
      .interval   (ramp_int[i]),
      .force_full (st_r.ovr),
      .duty       (ramp_duty[i])
    );
  end

  // ----------------------------------------------------------------
  // Registers, override and fan on/off state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (reg_wr_en) begin
      case (reg_addr)
        `FOHR_ADDR_RAMP_SLOW: st_nxt.regs.ramp_slow_config        = reg_wdata & `FOHR_MASK_RAMP_SLOW;
        `FOHR_ADDR_PROC_LIM:  st_nxt.regs.proc_control_temp_limit = reg_wdata;
        `FOHR_ADDR_REMOTE_ONE_RAMP_SELECT_ONE:  st_nxt.regs.acoustics_ctrl_one      = reg_wdata & `FOHR_MASK_REMOTE_ONE_RAMP_SELECT_ONE;
        `FOHR_ADDR_REMOTE_ONE_RAMP_SELECT_TWO:  st_nxt.regs.acoustics_ctrl_two      = reg_wdata & `FOHR_MASK_REMOTE_ONE_RAMP_SELECT_TWO;
        `FOHR_ADDR_R1_LIM:    st_nxt.regs.remote_one_crit_limit   = reg_wdata;
        `FOHR_ADDR_LOC_LIM:   st_nxt.regs.local_crit_limit        = reg_wdata;
        `FOHR_ADDR_R2_LIM:    st_nxt.regs.remote_two_crit_limit   = reg_wdata;
        `FOHR_ADDR_HYST_A:    st_nxt.regs.hyst_remote_one_local   = reg_wdata;
        `FOHR_ADDR_HYST_B:    st_nxt.regs.hyst_remote_two_proc    = reg_wdata;
        default: begin
        end
      endcase
    end

    case (reg_addr)
      `FOHR_ADDR_RAMP_SLOW: st_nxt.rdata = st_r.regs.ramp_slow_config;
      `FOHR_ADDR_PROC_LIM:  st_nxt.rdata = st_r.regs.proc_control_temp_limit;
      `FOHR_ADDR_REMOTE_ONE_RAMP_SELECT_ONE:  st_nxt.rdata = st_r.regs.acoustics_ctrl_one;
      `FOHR_ADDR_REMOTE_ONE_RAMP_SELECT_TWO:  st_nxt.rdata = st_r.regs.acoustics_ctrl_two;
      `FOHR_ADDR_R1_LIM:    st_nxt.rdata = st_r.regs.remote_one_crit_limit;
      `FOHR_ADDR_LOC_LIM:   st_nxt.rdata = st_r.regs.local_crit_limit;
      `FOHR_ADDR_R2_LIM:    st_nxt.rdata = st_r.regs.remote_two_crit_limit;
      `FOHR_ADDR_HYST_A:    st_nxt.rdata = st_r.regs.hyst_remote_one_local;
      `FOHR_ADDR_HYST_B:    st_nxt.rdata = st_r.regs.hyst_remote_two_proc;
      default:              st_nxt.rdata = 8'h00;
    endcase

    // Critical override per channel, independent of the curve settings
    for (int c = 0; c < 4; c++) begin
      if (chan_temp[c] > chan_lim[c]) begin
        st_nxt.crit[c] = 1'b1;
      end else if (chan_temp[c] < sat_sub(chan_lim[c], chan_hyst[c])) begin
        st_nxt.crit[c] = 1'b0;
      end
    end
    st_nxt.ovr = |st_nxt.crit;

    // Fan on/off with the same hysteresis as the override
    for (int o = 0; o < 3; o++) begin
      if (chan_temp[o] > curve_cfg[o].start_temp) begin
        st_nxt.fan_on[o] = 1'b1;
      end else if (chan_temp[o] < sat_sub(curve_cfg[o].start_temp, chan_hyst[o])) begin
        st_nxt.fan_on[o] = 1'b0;
      end
      st_nxt.duty[o] = st_nxt.ovr ? `FOHR_DUTY_FULL : ramp_duty[o];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.regs.ramp_slow_config        <= `FOHR_RST_RAMP_SLOW;
      st_r.regs.proc_control_temp_limit <= `FOHR_RST_PROC_LIM;
      st_r.regs.acoustics_ctrl_one      <= `FOHR_RST_REMOTE_ONE_RAMP_SELECT;
      st_r.regs.acoustics_ctrl_two      <= `FOHR_RST_REMOTE_ONE_RAMP_SELECT;
      st_r.regs.remote_one_crit_limit   <= `FOHR_RST_CRIT_LIM;
      st_r.regs.local_crit_limit        <= `FOHR_RST_CRIT_LIM;
      st_r.regs.remote_two_crit_limit   <= `FOHR_RST_CRIT_LIM;
      st_r.regs.hyst_remote_one_local   <= `FOHR_RST_HYST;
      st_r.regs.hyst_remote_two_proc    <= `FOHR_RST_HYST;
      st_r.crit                         <= 4'h0;
      st_r.ovr                          <= 1'b0;
      st_r.fan_on                       <= 3'h0;
      st_r.duty                         <= {3{`FOHR_DUTY_FULL}};
      st_r.rdata                        <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata       = st_r.rdata;
  assign pwm_duty        = st_r.duty;
  assign crit_active     = st_r.crit;
  assign override_active = st_r.ovr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_crit_full_out: assert property (@(posedge mclk) disable iff (!arst_n)
    (|st_r.crit) |-> (st_r.duty == {3{`FOHR_DUTY_FULL}}))
    else $error("override active but outputs not at full duty");

  a_max_not_limit: assert property (@(posedge mclk) disable iff (!arst_n)
    (chan_temp[0] > chan_lim[0] && curve_cfg[0].max_duty == 8'h00) |=> (st_r.duty[0] == `FOHR_DUTY_FULL))
    else $error("maximum duty held back the override");

  a_proc_limit: assert property (@(posedge mclk) disable iff (!arst_n)
    (chan_temp[3] > st_r.regs.proc_control_temp_limit) |=> (st_r.crit[3] && override_active))
    else $error("processor limit did not raise the override");

  for (genvar c = 0; c < 4; c++) begin : g_chk
    a_crit_set: assert property (@(posedge mclk) disable iff (!arst_n)
      (chan_temp[c] > chan_lim[c]) |=> st_r.crit[c])
      else $error("critical limit crossed without override");

    a_crit_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_r.crit[c] && chan_temp[c] >= sat_sub(chan_lim[c], chan_hyst[c])) |=> st_r.crit[c])
      else $error("override released inside hysteresis band");

    a_crit_release: assert property (@(posedge mclk) disable iff (!arst_n)
      (chan_temp[c] < sat_sub(chan_lim[c], chan_hyst[c])) |=> !st_r.crit[c])
      else $error("override not released below threshold");
  end

  a_min_off: assert property (@(posedge mclk) disable iff (!arst_n)
    (!st_r.fan_on[0] && !stay_on[0]) |-> (duty_tgt[0] == `FOHR_DUTY_OFF))
    else $error("output one not off below start minus hysteresis");

  a_stay_min: assert property (@(posedge mclk) disable iff (!arst_n)
    (stay_on[1] && chan_temp[1] <= curve_cfg[1].start_temp) |-> (duty_tgt[1] == curve_cfg[1].min_duty))
    else $error("stay-on output not at minimum duty");

  a_fan_off_thr: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_r.fan_on[2] && chan_temp[2] < sat_sub(curve_cfg[2].start_temp, chan_hyst[2])) |=> !st_r.fan_on[2])
    else $error("fan three stayed on below threshold");

endmodule

// *** verification/fohr_fan_model.sv ***
// Sensor and fan-side model for the supervisor bench
`timescale 1ns/100ps
module fohr_fan_model
  import fohr_pkg::*;
(
  // Sensor settings from the bench
  input  wire logic [3:0][7:0] temp_set,
  // Sensed temperatures
  output logic      [3:0][7:0] chan_temp
);
  assign chan_temp = temp_set;
endmodule

// *** verification/fohr_supervisor_tb_top.sv ***
// Self-checking bench for the fan supervisor
`timescale 1ns/100ps
module fohr_supervisor_tb_top
  import fohr_pkg::*;
;
  logic mclk = 1'b0, arst_n = 1'b0, reg_wr_en = 1'b0, override_active;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0][7:0] temp_set = '0, chan_temp;
  fohr_curve_s [2:0] curve_cfg;
  logic [2:0][7:0] pwm_duty;
  logic [3:0] crit_active;
  logic [23:0] vq[$], seen;
  logic [1:0] kq[$];
  int n_fail = 0, checks_done = 0, seed = 7747, gap;
  event look;
  const logic [7:0] ad[10] = '{8'h10, 8'h3D, 8'h62, 8'h63, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h11};
  const logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'h64, 8'h64, 8'h44, 8'h44, 8'h00};
  const logic [7:0] mk[10] = '{8'h87, 8'hFF, 8'hE7, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  const logic [7:0] lim[4] = '{8'h6A, 8'h6B, 8'h6C, 8'h3D};
  const int hy[4] = '{3, 5, 7, 2};
  const int msn[8] = '{37500, 18800, 12500, 7500, 4700, 3100, 1600, 800};
  const int msx[8] = '{52200, 26100, 17400, 10400, 6500, 4400, 2200, 1100};

  fohr_supervisor #(.CYC_PER_MS(1)) fohr_supervisor_inst (.mclk, .arst_n, .reg_wr_en, .reg_addr, .reg_wdata,
    .reg_rdata, .chan_temp, .curve_cfg, .pwm_duty, .crit_active, .override_active);
  fohr_fan_model fohr_fan_model_inst (.temp_set, .chan_temp);

  initial forever #25 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic compare(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [1:0] k, input logic [23:0] v);
    kq.push_back(k);
    vq.push_back(v);
    -> look;
  endtask
  always @(look) begin
    while (kq.size() > 0) begin
      case (kq[0])
        2'd0: seen = {16'h0000, reg_rdata};
        2'd1: seen = {19'h00000, override_active, crit_active};
        2'd2: seen = pwm_duty;
        default: seen = 24'(gap);
      endcase
      compare(seen, vq.pop_front());
      void'(kq.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    cyc(1);
    chk(2'd0, {16'h0000, e});
  endtask
  task automatic pulse();
    temp_set[0] = 8'hFF;
    cyc(2);
    temp_set[0] = 8'h00;
  endtask
  // Gap between the second and third duty step after release
  task automatic measure(input int o);
    logic [7:0] last;
    int bound;
    bound = 0;
    repeat (3) begin
      last = pwm_duty[o];
      gap = 0;
      while (pwm_duty[o] === last && bound < 4000) begin
        cyc(1);
        gap++;
        bound++;
      end
    end
    if (bound >= 4000) begin
      n_fail++;
      give_verdict();
    end
  endtask

  initial begin
    for (int i = 0; i < 3; i++) curve_cfg[i] = '{8'h20, 4'hF, 8'h00, 8'hFF};
    cyc(4);
    arst_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      logic [7:0] d;
      d = 8'($random(seed));
      if (i == 7 || i == 8) d = d | 8'h11;
      rd(ad[i], rv[i]);
      wr(ad[i], d);
      rd(ad[i], d & mk[i]);
    end
    for (int i = 0; i < 9; i++) wr(ad[i], rv[i]);
    $display("test registers done");
    for (int i = 0; i < 3; i++) curve_cfg[i].min_duty = 8'hF0;
    wr(8'h10, 8'h00);
    wr(8'h63, 8'h77);
    wr(8'h6A, 8'h50);
    wr(8'h62, 8'hE7);
    pulse();
    cyc(100);
    chk(2'd2, 24'hF0F0F0);
    wr(8'h62, 8'h07);
    cyc(800);
    chk(2'd2, 24'h000000);
    for (int i = 0; i < 3; i++) curve_cfg[i].min_duty = 8'h80;
    curve_cfg[1].max_duty = 8'hA0;
    temp_set = 32'h00484848;
    cyc(700);
    chk(2'd2, 24'hBFA0BF);
    $display("test curve done");
    curve_cfg[0].max_duty = 8'h00;
    wr(8'h6D, 8'h35);
    wr(8'h6E, 8'h72);
    for (int c = 0; c < 4; c++) begin
      wr(lim[c], 8'h50);
      temp_set[c] = 8'h51;
      cyc(1);
      chk(2'd1, 24'(16 + (1 << c)));
      chk(2'd2, 24'hFFFFFF);
      temp_set[c] = 8'(80 - hy[c]);
      cyc(3);
      chk(2'd1, 24'(16 + (1 << c)));
      temp_set[c] = 8'(79 - hy[c]);
      cyc(1);
      chk(2'd1, 24'h0);
    end
    $display("test override done");
    temp_set = '0;
    for (int i = 0; i < 3; i++) curve_cfg[i] = '{8'h20, 4'hF, 8'h00, 8'hFF};
    for (int i = 0; i < 16; i++) begin
      int o, code, slw, ext, exp;
      o = i % 3;
      code = i % 8;
      ext = i / 8;
      slw = $random(seed) & 1;
      wr(8'h10, 8'(ext * 128 + (slw << o)));
      wr(8'h62, o == 0 ? 8'(code) : 8'h00);
      wr(8'h63, 8'(o == 1 ? code : o == 2 ? code * 16 : 0));
      pulse();
      measure(o);
      exp = (ext == 1 ? msx[code] : msn[code]) * (slw == 1 ? 4 : 1) / 255;
      chk(2'd3, 24'(exp < 1 ? 1 : exp));
    end
    $display("test ramp done");
    give_verdict();
  end
endmodule
